// ---- rsfc_pkg.sv ----
// Shared constants and types for the remote serial flow control block
package rsfc_pkg;

  // ==========
  // Clock and timing
  // ==========
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_HZ_DEF    = 1000000000 / CLK_PERIOD_NS;
  localparam int DIV_W         = 18;

  // ==========
  // Remote port selection
  // ==========
  typedef enum logic [0:0] {
    RSFC_PORT_BUS    = 1'h0,
    RSFC_PORT_SERIAL = 1'h1
  } rsfc_port_t;
  localparam rsfc_port_t PORT_DEF = RSFC_PORT_BUS;

  // ==========
  // Instrument-bus address
  // ==========
  localparam int         ADDR_W   = 5;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic [4:0] ADDR_DEF = 5'h0a;

  // ==========
  // Baud rate selection
  // ==========
  localparam int         BAUD_SEL_W = 4;
  localparam logic [3:0] BAUD_NUM   = 4'ha;
  localparam logic [3:0] BAUD_DEF   = 4'h8;

  function automatic int baud_rate(input logic [3:0] sel);
    int r;
    r = 57600;
    unique case (sel)
      4'h0: r = 300;
      4'h1: r = 600;
      4'h2: r = 1200;
      4'h3: r = 2400;
      4'h4: r = 4800;
      4'h5: r = 9600;
      4'h6: r = 19200;
      4'h7: r = 38400;
      4'h8: r = 57600;
      4'h9: r = 115200;
      default: r = 57600;
    endcase
    return r;
  endfunction

  // ==========
  // Parity and flow control
  // ==========
  typedef enum logic [1:0] {
    RSFC_PAR_NONE = 2'h0,
    RSFC_PAR_EVEN = 2'h1,
    RSFC_PAR_ODD  = 2'h2
  } rsfc_par_t;
  localparam rsfc_par_t  PAR_DEF     = RSFC_PAR_NONE;
  localparam logic [1:0] PAR_ILLEGAL = 2'h3;

  typedef enum logic [2:0] {
    RSFC_FLOW_NONE    = 3'h0,
    RSFC_FLOW_DTR_DSR = 3'h1,
    RSFC_FLOW_MODEM   = 3'h2,
    RSFC_FLOW_RTS_CTS = 3'h3,
    RSFC_FLOW_XON     = 3'h4
  } rsfc_flow_t;
  localparam rsfc_flow_t FLOW_DEF = RSFC_FLOW_DTR_DSR;
  localparam logic [2:0] FLOW_MAX = 3'h4;

  localparam logic [7:0] XOFF_CHAR = 8'h13;
  localparam logic [7:0] XON_CHAR  = 8'h11;

  // ==========
  // Receive buffer
  // ==========
  localparam int         BUF_AW    = 7;
  localparam int         CNT_W     = 8;
  localparam logic [7:0] BUF_DEPTH = 8'h80;
  localparam logic [7:0] BUF_HIGH  = 8'h64;
  localparam logic [7:0] BUF_LOW   = 8'h50;

  // Serial frame: 8 payload bits, index of last one
  localparam logic [2:0] LAST_BIT  = 3'h7;
  // Reset value of synchronised {rxd, dsr, cts}
  localparam logic [2:0] SYNC_RST  = 3'h4;

endpackage

// ---- rsfc_buf_if.sv ----
// Link between the serial controller and its receive buffer memory
`timescale 1ns/1ps
interface rsfc_buf_if;
  import rsfc_pkg::*;
  logic              wr_en;
  logic [BUF_AW-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic [BUF_AW-1:0] rd_addr;
  logic [7:0]        rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
                input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                output rd_data);
endinterface

// ---- rsfc_rxbuf.sv ----
// Receive character buffer memory with registered read data
`timescale 1ns/1ps
module rsfc_rxbuf
  import rsfc_pkg::*;
(
  // Clock and reset
  input  wire logic  clk_in,
  input  wire logic  sys_rst_in,
  // Buffer port
  rsfc_buf_if.mem    buf_if
);

  logic [7:0] mem_q [0:(1<<BUF_AW)-1];
  logic [7:0] rd_q;

  always_ff @(posedge clk_in)
  begin
    if (buf_if.wr_en)
    begin
      mem_q[buf_if.wr_addr] <= buf_if.wr_data;
    end
  end

  // Forward a write to the location being read
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      rd_q <= 8'h00;
    end
    else if (buf_if.wr_en && (buf_if.wr_addr == buf_if.rd_addr))
    begin
      rd_q <= buf_if.wr_data;
    end
    else
    begin
      rd_q <= mem_q[buf_if.rd_addr];
    end
  end

  assign buf_if.rd_data = rd_q;

endmodule

// ---- rsfc_top.sv ----
// Remote interface selection, settings and RS-232 flow-controlled serial port
`timescale 1ns/1ps
// What this block does
// (RULE_01) Exactly one remote port is active; instrument bus is the default.
// (RULE_02) Bus address 0 to 30 accepted, default 10, unique on the bus.
// (RULE_03) Settings are kept across a remote-interface reset and saved externally.
// (RULE_04) Ten baud rates from 300 to 115200; default 57600.
// (RULE_05) No parity means 8 data bits; even or odd means 7 bits.
// (RULE_06) Five flow schemes: none, DTR/DSR, modem, RTS/CTS, XON/XOFF; default DTR/DSR.
// (RULE_07) With no flow control the host keeps rate and bursts low.
// (RULE_08) DTR/DSR mode transmits only while DSR is true.
// (RULE_09) DTR/DSR mode drops DTR near 100 buffered characters, raises it later.
// (RULE_10) Modem mode raises DTR on serial selection, RTS when ready to receive.
// (RULE_11) Modem raises DSR while on-line and CTS while it accepts data.
// (RULE_12) RTS/CTS mode transmits only while CTS is true.
// (RULE_13) Modem and RTS/CTS modes drop RTS near 100 characters, raise it later.
// (RULE_14) XON/XOFF mode halts on received 13h and resumes on 11h.
// (RULE_15) Host sends binary blocks without XON/XOFF, 8 bits, pausing 1 ms.
// (RULE_16) Receive buffer holds 128 characters, room beyond the 100 threshold.
module rsfc_top
  import rsfc_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF
)
(
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  rif_rst_in,
  // Settings write
  input  wire logic                  cfg_wr_in,
  input  wire logic                  cfg_port_in,
  input  wire logic [ADDR_W-1:0]     cfg_addr_in,
  input  wire logic [BAUD_SEL_W-1:0] cfg_baud_in,
  input  wire logic [1:0]            cfg_par_in,
  input  wire logic [2:0]            cfg_flow_in,
  // Settings state for non-volatile storage
  output logic                       cfg_port_out,
  output logic [ADDR_W-1:0]          cfg_addr_out,
  output logic [BAUD_SEL_W-1:0]      cfg_baud_out,
  output logic [1:0]                 cfg_par_out,
  output logic [2:0]                 cfg_flow_out,
  output logic                       bus_active_out,
  output logic                       serial_active_out,
  // Transmit stream
  input  wire logic                  tx_valid_in,
  input  wire logic [7:0]            tx_data_in,
  output logic                       tx_ready_out,
  // Receive stream
  output logic                       rx_valid_out,
  output logic [7:0]                 rx_data_out,
  input  wire logic                  rx_ready_in,
  output logic                       rx_par_err_out,
  output logic                       rx_frame_err_out,
  output logic                       rx_overrun_out,
  output logic                       tx_halted_out,
  // RS-232 pins
  input  wire logic                  rxd_in,
  input  wire logic                  dsr_in,
  input  wire logic                  cts_in,
  output logic                       txd_out,
  output logic                       dtr_out,
  output logic                       rts_out
);

  typedef enum logic [1:0] {
    RSFC_S_IDLE  = 2'h0,
    RSFC_S_START = 2'h1,
    RSFC_S_BITS  = 2'h2,
    RSFC_S_STOP  = 2'h3
  } rsfc_state_t;

  function automatic logic [DIV_W-1:0] baud_div(input logic [3:0] sel);
    int r;
    r = CLK_HZ / baud_rate(sel);
    return DIV_W'(r);
  endfunction

  function automatic logic par_bit(input rsfc_par_t par, input logic [6:0] d);
    return (par == RSFC_PAR_ODD) ? ~(^d) : (^d);
  endfunction

  // ==========
  // Pin synchronisers
  // ==========
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       rxd_s;
  logic       dsr_s;
  logic       cts_s;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
    end
    else
    begin
      meta_q <= {rxd_in, dsr_in, cts_in};
      sync_q <= meta_q;
    end
  end
  assign {rxd_s, dsr_s, cts_s} = sync_q;

  // ==========
  // Settings
  // ==========
  rsfc_port_t              port_q, port_d;
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic [BAUD_SEL_W-1:0]   baud_q, baud_d;
  rsfc_par_t               par_q, par_d;
  rsfc_flow_t              flow_q, flow_d;
  logic                    serial_on;
  logic [DIV_W-1:0]        div;

  always_comb
  begin
    port_d = port_q;
    addr_d = addr_q;
    baud_d = baud_q;
    par_d  = par_q;
    flow_d = flow_q;
    if (cfg_wr_in)
    begin
      port_d = rsfc_port_t'(cfg_port_in); // RULE_01
      if (cfg_addr_in <= ADDR_MAX)
      begin
        addr_d = cfg_addr_in; // RULE_02
      end
      if (cfg_baud_in < BAUD_NUM)
      begin
        baud_d = cfg_baud_in; // RULE_04
      end
      if (cfg_par_in != PAR_ILLEGAL)
      begin
        par_d = rsfc_par_t'(cfg_par_in); // RULE_05
      end
      if (cfg_flow_in <= FLOW_MAX)
      begin
        flow_d = rsfc_flow_t'(cfg_flow_in); // RULE_06
      end
    end
  end

  // Remote-interface reset leaves the settings alone
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      port_q <= PORT_DEF; // RULE_01
      addr_q <= ADDR_DEF; // RULE_02
      baud_q <= BAUD_DEF; // RULE_04
      par_q  <= PAR_DEF; // RULE_05
      flow_q <= FLOW_DEF; // RULE_06
    end
    else
    begin
      port_q <= port_d; // RULE_03
      addr_q <= addr_d;
      baud_q <= baud_d;
      par_q  <= par_d;
      flow_q <= flow_d;
    end
  end

  assign serial_on         = (port_q == RSFC_PORT_SERIAL);
  assign serial_active_out = serial_on; // RULE_01
  assign bus_active_out    = ~serial_on; // RULE_01
  assign cfg_port_out      = port_q;
  assign cfg_addr_out      = addr_q;
  assign cfg_baud_out      = baud_q;
  assign cfg_par_out       = par_q;
  assign cfg_flow_out      = flow_q;
  assign div               = baud_div(baud_q); // RULE_04

  // ==========
  // Transmitter
  // ==========
  rsfc_state_t      tx_st_q, tx_st_d;
  logic [DIV_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [2:0]       tx_idx_q, tx_idx_d;
  logic [7:0]       tx_sh_q, tx_sh_d;
  logic             txd_q, txd_d;
  logic             xoff_q, xoff_d;
  logic             tx_gate;

  // Gate is checked per character, so a stop lands within one character
  always_comb
  begin
    unique case (flow_q)
      RSFC_FLOW_NONE:    tx_gate = 1'b1;
      RSFC_FLOW_DTR_DSR: tx_gate = dsr_s; // RULE_08
      RSFC_FLOW_MODEM:   tx_gate = dsr_s & cts_s; // RULE_11
      RSFC_FLOW_RTS_CTS: tx_gate = cts_s; // RULE_12
      RSFC_FLOW_XON:     tx_gate = ~xoff_q; // RULE_14
      default:           tx_gate = 1'b0;
    endcase
  end

  assign tx_ready_out  = serial_on & ~rif_rst_in & tx_gate & (tx_st_q == RSFC_S_IDLE);
  assign tx_halted_out = serial_on & ~tx_gate;

  always_comb
  begin
    tx_st_d  = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_idx_d = tx_idx_q;
    tx_sh_d  = tx_sh_q;
    txd_d    = txd_q;
    if (tx_st_q != RSFC_S_IDLE)
    begin
      tx_cnt_d = tx_cnt_q - 1'b1;
    end
    unique case (tx_st_q)
      RSFC_S_IDLE:
      begin
        txd_d = 1'b1;
        if (tx_valid_in && tx_ready_out)
        begin
          tx_sh_d  = tx_data_in;
          if (par_q != RSFC_PAR_NONE)
          begin
            tx_sh_d[7] = par_bit(par_q, tx_data_in[6:0]); // RULE_05
          end
          tx_cnt_d = div - 1'b1;
          tx_st_d  = RSFC_S_START;
          txd_d    = 1'b0;
        end
      end
      RSFC_S_START,
      RSFC_S_BITS:
      begin
        if (tx_cnt_q == '0)
        begin
          tx_cnt_d = div - 1'b1;
          if ((tx_st_q == RSFC_S_BITS) && (tx_idx_q == LAST_BIT))
          begin
            tx_st_d = RSFC_S_STOP;
            txd_d   = 1'b1;
          end
          else
          begin
            tx_idx_d = (tx_st_q == RSFC_S_START) ? 3'h0 : tx_idx_q + 3'h1;
            tx_st_d  = RSFC_S_BITS;
            txd_d    = tx_sh_q[0];
            tx_sh_d  = {1'b0, tx_sh_q[7:1]};
          end
        end
      end
      RSFC_S_STOP:
      begin
        if (tx_cnt_q == '0)
        begin
          tx_st_d = RSFC_S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || rif_rst_in)
    begin
      tx_st_q  <= RSFC_S_IDLE;
      tx_cnt_q <= '0;
      tx_idx_q <= 3'h0;
      tx_sh_q  <= 8'h00;
      txd_q    <= 1'b1;
    end
    else
    begin
      tx_st_q  <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_idx_q <= tx_idx_d;
      tx_sh_q  <= tx_sh_d;
      txd_q    <= txd_d;
    end
  end
  assign txd_out = txd_q;

  // ==========
  // Receiver
  // ==========
  rsfc_state_t      rx_st_q, rx_st_d;
  logic [DIV_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [2:0]       rx_idx_q, rx_idx_d;
  logic [7:0]       rx_sh_q, rx_sh_d;
  logic             perr_q, perr_d;
  logic             ferr_q, ferr_d;
  logic             ovr_q, ovr_d;
  logic             push;
  logic [7:0]       rx_char;
  logic [CNT_W-1:0] cnt_q;

  assign rx_char = (par_q == RSFC_PAR_NONE) ? rx_sh_q : {1'b0, rx_sh_q[6:0]}; // RULE_05

  always_comb
  begin
    rx_st_d  = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_idx_d = rx_idx_q;
    rx_sh_d  = rx_sh_q;
    perr_d   = 1'b0;
    ferr_d   = 1'b0;
    ovr_d    = 1'b0;
    push     = 1'b0;
    xoff_d   = (flow_q == RSFC_FLOW_XON) ? xoff_q : 1'b0;
    if (rx_st_q != RSFC_S_IDLE)
    begin
      rx_cnt_d = rx_cnt_q - 1'b1;
    end
    unique case (rx_st_q)
      RSFC_S_IDLE:
      begin
        if (serial_on && !rxd_s)
        begin
          rx_cnt_d = (div >> 1) - 1'b1;
          rx_st_d  = RSFC_S_START;
        end
      end
      RSFC_S_START:
      begin
        if (rx_cnt_q == '0)
        begin
          rx_cnt_d = div - 1'b1;
          rx_idx_d = 3'h0;
          rx_st_d  = rxd_s ? RSFC_S_IDLE : RSFC_S_BITS;
        end
      end
      RSFC_S_BITS:
      begin
        if (rx_cnt_q == '0)
        begin
          rx_cnt_d = div - 1'b1;
          rx_sh_d  = {rxd_s, rx_sh_q[7:1]};
          rx_idx_d = rx_idx_q + 3'h1;
          if (rx_idx_q == LAST_BIT)
          begin
            rx_st_d = RSFC_S_STOP;
          end
        end
      end
      RSFC_S_STOP:
      begin
        if (rx_cnt_q == '0)
        begin
          rx_st_d = RSFC_S_IDLE;
          ferr_d  = ~rxd_s;
          perr_d  = (par_q != RSFC_PAR_NONE) &&
                    (rx_sh_q[7] != par_bit(par_q, rx_sh_q[6:0]));
          if ((flow_q == RSFC_FLOW_XON) && (rx_char == XOFF_CHAR))
          begin
            xoff_d = 1'b1; // RULE_14
          end
          else if ((flow_q == RSFC_FLOW_XON) && (rx_char == XON_CHAR))
          begin
            xoff_d = 1'b0; // RULE_14
          end
          else if (cnt_q == BUF_DEPTH)
          begin
            ovr_d = 1'b1;
          end
          else
          begin
            push = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || rif_rst_in)
    begin
      rx_st_q  <= RSFC_S_IDLE;
      rx_cnt_q <= '0;
      rx_idx_q <= 3'h0;
      rx_sh_q  <= 8'h00;
      perr_q   <= 1'b0;
      ferr_q   <= 1'b0;
      ovr_q    <= 1'b0;
      xoff_q   <= 1'b0;
    end
    else
    begin
      rx_st_q  <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_idx_q <= rx_idx_d;
      rx_sh_q  <= rx_sh_d;
      perr_q   <= perr_d;
      ferr_q   <= ferr_d;
      ovr_q    <= ovr_d;
      xoff_q   <= xoff_d;
    end
  end
  assign rx_par_err_out   = perr_q;
  assign rx_frame_err_out = ferr_q;
  assign rx_overrun_out   = ovr_q;

  // ==========
  // Receive buffer and line control outputs
  // ==========
  logic [BUF_AW-1:0] wr_ptr_q, wr_ptr_d;
  logic [BUF_AW-1:0] rd_ptr_q, rd_ptr_d;
  logic [CNT_W-1:0]  cnt_d;
  logic              full_q, full_d;
  logic              dtr_q, dtr_d;
  logic              rts_q, rts_d;
  logic              pop;

  rsfc_buf_if buf_if ();

  rsfc_rxbuf u_rxbuf (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .buf_if     (buf_if.mem) // RULE_16
  );

  assign rx_valid_out   = (cnt_q != '0);
  assign rx_data_out    = buf_if.rd_data;
  assign pop            = rx_valid_out & rx_ready_in;
  assign buf_if.wr_en   = push;
  assign buf_if.wr_addr = wr_ptr_q;
  assign buf_if.wr_data = rx_char;
  assign buf_if.rd_addr = rd_ptr_d;

  always_comb
  begin
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    cnt_d    = cnt_q + CNT_W'(push) - CNT_W'(pop);
    full_d   = full_q;
    if (cnt_d >= BUF_HIGH)
    begin
      full_d = 1'b1; // RULE_09 RULE_13
    end
    else if (cnt_d < BUF_LOW)
    begin
      full_d = 1'b0;
    end
    dtr_d = serial_on; // RULE_10
    rts_d = serial_on; // RULE_10
    if (flow_q == RSFC_FLOW_DTR_DSR)
    begin
      dtr_d = serial_on & ~full_d; // RULE_09
    end
    if ((flow_q == RSFC_FLOW_MODEM) || (flow_q == RSFC_FLOW_RTS_CTS))
    begin
      rts_d = serial_on & ~full_d; // RULE_13
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || rif_rst_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
      full_q   <= 1'b0;
      dtr_q    <= 1'b0;
      rts_q    <= 1'b0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q    <= cnt_d;
      full_q   <= full_d;
      dtr_q    <= dtr_d;
      rts_q    <= rts_d;
    end
  end
  assign dtr_out = dtr_q;
  assign rts_out = rts_q;

endmodule

// ---- rsfc_top_checker.sv ----
// Concurrent property checker for the remote serial flow control top level
`timescale 1ns/1ps
module rsfc_top_checker
  import rsfc_pkg::*;
(
  // Clock and resets
  input logic       clk_in,
  input logic       sys_rst_in,
  input logic       rif_rst_in,
  // Settings
  input logic       cfg_wr_in,
  input logic [4:0] cfg_addr_in,
  input logic [1:0] cfg_par_in,
  input logic [2:0] cfg_flow_in,
  input logic       cfg_port_out,
  input logic [4:0] cfg_addr_out,
  input logic [1:0] cfg_par_out,
  input logic [2:0] cfg_flow_out,
  input logic       bus_active_out,
  input logic       serial_active_out,
  // Stream and pins
  input logic       tx_valid_in,
  input logic       tx_ready_out,
  input logic       tx_halted_out,
  input logic       dsr_in,
  input logic       cts_in,
  input logic       txd_out,
  input logic       dtr_out,
  input logic       rts_out
);
  // ==========
  // Assertions
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  AST_ONE_PORT: assert property (bus_active_out != serial_active_out)
    else $error("ports not exclusive");
  AST_ADDR_SET: assert property (cfg_wr_in && cfg_addr_in <= 5'h1e |=>
    cfg_addr_out == $past(cfg_addr_in)) else $error("legal address not taken");
  AST_ADDR_KEEP: assert property (cfg_wr_in && cfg_addr_in > 5'h1e |=>
    $stable(cfg_addr_out)) else $error("illegal address taken");
  AST_PAR_KEEP: assert property (cfg_wr_in && cfg_par_in == 2'h3 |=>
    $stable(cfg_par_out)) else $error("illegal parity taken");
  AST_FLOW_KEEP: assert property (cfg_wr_in && cfg_flow_in > 3'h4 |=>
    $stable(cfg_flow_out)) else $error("illegal flow mode taken");
  AST_RIF_KEEP: assert property (rif_rst_in && !cfg_wr_in |=>
    $stable({cfg_port_out, cfg_addr_out, cfg_par_out, cfg_flow_out}))
    else $error("settings lost");
  AST_DSR_GATE: assert property ((serial_active_out && cfg_flow_out == 3'h1 && !dsr_in) [*4]
    |-> !tx_ready_out) else $error("ready without DSR");
  AST_CTS_GATE: assert property ((serial_active_out && cfg_flow_out == 3'h3 && !cts_in) [*4]
    |-> !tx_ready_out) else $error("ready without CTS");
  AST_MODEM_DTR: assert property ((serial_active_out && cfg_flow_out == 3'h2 && !rif_rst_in) [*2]
    |-> dtr_out) else $error("DTR low in modem mode");
  AST_BUS_QUIET: assert property ((!serial_active_out) [*2] |-> !dtr_out && !rts_out)
    else $error("lines driven on bus port");
  AST_TX_START: assert property (@(posedge clk_in) disable iff (sys_rst_in || rif_rst_in)
    tx_valid_in && tx_ready_out |=> !txd_out [*2]) else $error("start bit missing");

  COV_TX_TAKE: cover property (tx_valid_in && tx_ready_out);
  COV_XOFF: cover property (cfg_flow_out == 3'h4 && tx_halted_out);
  COV_RTS_DROP: cover property (serial_active_out && $fell(rts_out));
endmodule

bind rsfc_top rsfc_top_checker i_rsfc_top_checker (.clk_in, .sys_rst_in, .rif_rst_in,
  .cfg_wr_in, .cfg_addr_in, .cfg_par_in, .cfg_flow_in, .cfg_port_out, .cfg_addr_out,
  .cfg_par_out, .cfg_flow_out, .bus_active_out, .serial_active_out, .tx_valid_in,
  .tx_ready_out, .tx_halted_out, .dsr_in, .cts_in, .txd_out, .dtr_out, .rts_out);

// ---- rsfc_host.sv ----
// Behavioural host computer or modem on the serial pins
`timescale 1ns/1ps
module rsfc_host
(
  // Clock
  input  logic       clk_in,
  // Serial pins
  input  logic       txd_in,
  output logic       rxd_out,
  output logic       dsr_out,
  output logic       cts_out,
  // Bench control
  input  logic       dsr_req_in,
  input  logic       cts_req_in,
  input  int         div_in,
  output logic       got_stb_out,
  output logic [8:0] got_out
);
  // ==========
  // Handshake lines
  assign dsr_out = dsr_req_in;
  assign cts_out = cts_req_in;

  initial
  begin
    rxd_out = 1'b1;
    got_stb_out = 1'b0;
    got_out = 9'h000;
  end

  // ==========
  // Frame to the device, mark level between frames
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk_in);
      rxd_out = f[i];
      repeat (div_in - 1) @(negedge clk_in);
    end
  endtask

  // ==========
  // Mid-bit receiver, stop bit reported in bit 8
  always
  begin
    @(negedge txd_in);
    repeat (div_in / 2) @(posedge clk_in);
    for (int i = 0; i < 9; i++)
    begin
      repeat (div_in) @(posedge clk_in);
      got_out[i] <= txd_in;
    end
    got_stb_out <= 1'b1;
    @(posedge clk_in);
    got_stb_out <= 1'b0;
  end
endmodule

// ---- tb_rsfc_top.sv ----
// Self-checking testbench for the remote serial flow control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb_rsfc_top
  import rsfc_pkg::*;
;
  localparam int HZ = 1152000;
  logic       clk_in = 1'b0, sys_rst_in = 1'b1, rif_rst_in = 1'b0, cfg_wr_in = 1'b0;
  logic       cfg_port_in = 1'b0, tx_valid_in = 1'b0, rx_ready_in = 1'b1, perr_exp = 1'b0;
  logic [4:0] cfg_addr_in = 5'h00;
  logic [3:0] cfg_baud_in = 4'h0;
  logic [1:0] cfg_par_in = 2'h0;
  logic [2:0] cfg_flow_in = 3'h0;
  logic [7:0] tx_data_in = 8'h00;
  logic       rxd_in, dsr_in, cts_in, dsr_req = 1'b1, cts_req = 1'b1, got_stb;
  logic       cfg_port_out, bus_active_out, serial_active_out, tx_ready_out, rx_valid_out;
  logic       rx_par_err_out, rx_frame_err_out, rx_overrun_out, tx_halted_out;
  logic       txd_out, dtr_out, rts_out;
  logic [4:0] cfg_addr_out;
  logic [3:0] cfg_baud_out;
  logic [1:0] cfg_par_out;
  logic [2:0] cfg_flow_out;
  logic [7:0] rx_data_out, re;
  logic [8:0] got, te;
  logic [7:0] rxq[$];
  logic [8:0] txq[$];
  int         div = 10, fail_count = 0, checks = 0, perr_n = 0;
  wire  [2:0] errs = {rx_par_err_out, rx_frame_err_out, rx_overrun_out};

  always #10 clk_in = ~clk_in;

  rsfc_top #(.CLK_HZ(HZ)) i_rsfc_top (.clk_in, .sys_rst_in, .rif_rst_in, .cfg_wr_in,
    .cfg_port_in, .cfg_addr_in, .cfg_baud_in, .cfg_par_in, .cfg_flow_in, .cfg_port_out,
    .cfg_addr_out, .cfg_baud_out, .cfg_par_out, .cfg_flow_out, .bus_active_out,
    .serial_active_out, .tx_valid_in, .tx_data_in, .tx_ready_out, .rx_valid_out,
    .rx_data_out, .rx_ready_in, .rx_par_err_out, .rx_frame_err_out, .rx_overrun_out,
    .tx_halted_out, .rxd_in, .dsr_in, .cts_in, .txd_out, .dtr_out, .rts_out);

  rsfc_host i_host (.clk_in, .txd_in(txd_out), .rxd_out(rxd_in), .dsr_out(dsr_in),
    .cts_out(cts_in), .dsr_req_in(dsr_req), .cts_req_in(cts_req), .div_in(div),
    .got_stb_out(got_stb), .got_out(got));

  // ==========
  // Tasks
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic tend(input string s);
    $display("Test %s finished", s);
  endtask

  task automatic cfg(input logic p, input logic [4:0] a, input logic [3:0] b,
                     input logic [1:0] r, input logic [2:0] f);
    @(negedge clk_in);
    {cfg_port_in, cfg_addr_in, cfg_baud_in, cfg_par_in, cfg_flow_in} = {p, a, b, r, f};
    cfg_wr_in = 1'b1;
    @(negedge clk_in);
    cfg_wr_in = 1'b0;
    repeat (5) @(negedge clk_in);
  endtask

  // Bounded wait: 0 for transmit ready, 1 for receive buffer empty
  task automatic wait_for(input int w);
    int n;
    for (n = 0; n < 5000 && ((w == 0) ? tx_ready_out : !rx_valid_out) !== 1'b1; n++)
      @(negedge clk_in);
    if (n == 5000)
    begin
      fail_count++;
      stop_test;
    end
  endtask

  task automatic send_tx(input logic [7:0] d, input logic [8:0] e);
    wait_for(0);
    txq.push_back(e);
    tx_data_in = d;
    tx_valid_in = 1'b1;
    @(negedge clk_in);
    tx_valid_in = 1'b0;
  endtask

  // ==========
  // Result monitor
  always @(posedge clk_in)
  begin
    if (rx_valid_out === 1'b1 && rx_ready_in === 1'b1)
    begin
      re = rxq.pop_front();
      `CHK("rx_data_out", re, rx_data_out)
    end
    if (got_stb === 1'b1)
    begin
      te = txq.pop_front();
      `CHK("host_char", te, got)
    end
    if (errs !== 3'h0)
      `CHK("rx_errors", {perr_exp, 2'h0}, errs)
    if (errs[2] === 1'b1)
      perr_n++;
  end

  initial
  begin
    repeat (100000) @(posedge clk_in);
    fail_count++;
    stop_test;
  end

  // ==========
  // Main sequence
  initial
  begin
    logic [7:0] d;
    logic       pb;
    logic       closed;
    void'($urandom(65586));
    repeat (4) @(negedge clk_in);
    sys_rst_in = 1'b0;
    `CHK("port", 2'h1, {cfg_port_out, bus_active_out})
    `CHK("addr", 5'h0a, cfg_addr_out)
    `CHK("settings", 9'h101, {cfg_baud_out, cfg_par_out, cfg_flow_out})
    `CHK("pins", 3'h0, {dtr_out, rts_out, tx_ready_out})
    tend("defaults");
    cfg(1'b0, 5'h1f, 4'ha, 2'h3, 3'h5);
    `CHK("refused", 14'h1501, {cfg_addr_out, cfg_baud_out, cfg_par_out, cfg_flow_out})
    cfg(1'b0, 5'h1e, 4'h9, 2'h2, 3'h4);
    `CHK("limits", 14'h3d34, {cfg_addr_out, cfg_baud_out, cfg_par_out, cfg_flow_out})
    tend("ranges");
    for (int f = 0; f < 5; f++)
    begin
      cfg(1'b1, 5'h00, 4'h9, 2'h0, 3'(f));
      `CHK("serial_lines", 4'hb, {serial_active_out, bus_active_out, dtr_out, rts_out})
    end
    cfg(1'b0, 5'h00, 4'h9, 2'h0, 3'h2);
    `CHK("bus_lines", 4'h4, {serial_active_out, bus_active_out, dtr_out, rts_out})
    `CHK("addr_zero", 5'h00, cfg_addr_out)
    tend("ports");
    for (int p = 0; p < 3; p++)
      for (int b = 8; b < 10; b++)
      begin
        cfg(1'b1, 5'h00, 4'(b), 2'(p), 3'h0);
        div = HZ / ((b == 8) ? 57600 : 115200);
        d = 8'($urandom);
        pb = (p == 0) ? d[7] : (p == 1) ? ^d[6:0] : ~^d[6:0];
        repeat (2) send_tx(d, {1'b1, pb, d[6:0]});
        rxq.push_back((p == 0) ? d : {1'b0, d[6:0]});
        i_host.send({pb, d[6:0]});
        wait_for(0);
      end
    perr_exp = 1'b1;
    rxq.push_back({1'b0, d[6:0]});
    i_host.send({~pb, d[6:0]});
    perr_exp = 1'b0;
    `CHK("par_errors", 1, perr_n)
    tend("frames");
    for (int f = 1; f < 4; f++)
      for (int k = 0; k < 4; k++)
      begin
        {dsr_req, cts_req} = 2'(k);
        cfg(1'b1, 5'h00, 4'h9, 2'h0, 3'(f));
        closed = (f == 1) ? !dsr_req : (f == 2) ? !(dsr_req && cts_req) : !cts_req;
        `CHK("gate", {closed, !closed}, {tx_halted_out, tx_ready_out})
      end
    tend("gates");
    cfg(1'b1, 5'h00, 4'h9, 2'h0, 3'h4);
    i_host.send(8'h13);
    repeat (3) @(negedge clk_in);
    `CHK("xoff", 2'h2, {tx_halted_out, tx_ready_out})
    i_host.send(8'h11);
    repeat (3) @(negedge clk_in);
    `CHK("xon", 2'h1, {tx_halted_out, tx_ready_out})
    tend("xon_xoff");
    rif_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rif_rst_in = 1'b0;
    `CHK("kept", 10'h324, {cfg_port_out, cfg_baud_out, cfg_par_out, cfg_flow_out})
    tend("interface_reset");
    cfg(1'b1, 5'h00, 4'h9, 2'h0, 3'h3);
    rx_ready_in = 1'b0;
    for (int i = 0; i < 120; i++)
    begin
      if (i == 99 || i == 100)
        `CHK("rts_level", i == 99, rts_out)
      d = 8'($urandom);
      rxq.push_back(d);
      i_host.send(d);
    end
    cfg(1'b1, 5'h00, 4'h9, 2'h0, 3'h1);
    `CHK("dtr_full", 2'h1, {dtr_out, rts_out})
    rx_ready_in = 1'b1;
    wait_for(1);
    repeat (2) @(negedge clk_in);
    `CHK("dtr_free", 2'h3, {dtr_out, rts_out})
    `CHK("pending", 0, rxq.size() + txq.size())
    tend("thresholds");
    stop_test;
  end
endmodule
